// File: include/serial_pkg.sv
package serial_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets on the bus.
   // ---------------------------------------------------------------
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_STAT = 5'h04;
   localparam logic [4:0] OFF_TXB = 5'h08;
   localparam logic [4:0] OFF_RXB = 5'h0C;
   localparam logic [4:0] OFF_IRC = 5'h10;
   localparam logic [4:0] OFF_BAUD = 5'h14;

   // ---------------------------------------------------------------
   // Reset values and timing.
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] IRC_RST = 8'h00;
   localparam logic [15:0] BAUD_RST = 16'h001F;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] PWS_DEFAULT = 3'h0;
   localparam int CLK_PERIOD_NS = 50;
   localparam int PULSE_MIN_NS = 1410;
   // Least time, so round up to whole cycles.
   localparam int PULSE_MIN_CYC =
      (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Register layouts.
   // ---------------------------------------------------------------
   typedef struct packed {
      logic sync_mode;
      logic clock_source_sel1;
      logic clock_source_sel0;
      logic tx_irq_enable;
      logic rx_irq_enable;
      logic tx_end_irq_enable;
      logic transmitter_enable;
      logic receiver_enable;
   } ctrl_s;

   typedef struct packed {
      logic tx_empty_flag;
      logic rx_full_flag;
      logic overrun_flag;
      logic framing_flag;
      logic parity_flag;
      logic tx_end_flag;
      logic [1:0] unused;
   } status_s;

   typedef struct packed {
      logic infrared_enable;
      logic [2:0] pulse_width_select;
      logic [3:0] unused;
   } irc_s;

endpackage

// File: rtl/sync_serial_ir.sv
`timescale 1ns/1ps
module sync_serial_ir
   import serial_pkg::*;
#(
   parameter int BAUD_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:2] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic ack_o,
   output logic [31:0] dat_o,
   input wire logic serial_clock_pin_a_i,
   output logic serial_clock_pin_a_o,
   output logic serial_clock_pin_a_oe_o,
   input wire logic receive_pin_a_i,
   output logic transmit_pin_a_o,
   output logic tx_empty_request_o,
   output logic tx_end_request_o,
   output logic rx_full_request_o,
   output logic rx_error_request_o
);

   // ---------------------------------------------------------------
   // Elaboration check.
   // ---------------------------------------------------------------
   if (BAUD_W < 6 || BAUD_W > 16) begin : g_chk
      $error("BAUD_W must lie between 6 and 16");
   end

   // ---------------------------------------------------------------
   // State.
   // ---------------------------------------------------------------
   ctrl_s ctrl_q, ctrl_d;
   irc_s irc_q, irc_d;
   status_s stat_w;
   logic [BAUD_W-1:0] baud_q, baud_d;
   logic [BAUD_W-1:0] div_q, div_d;
   logic [BAUD_W-1:0] ir_cnt_q, ir_cnt_d;
   logic [BAUD_W-1:0] pulse_w;
   logic [BAUD_W+2:0] p3_w;
   logic [7:0] tx_buf_q, tx_buf_d;
   logic [7:0] rx_buf_q, rx_buf_d;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic [7:0] rx_sh_q, rx_sh_d;
   logic [2:0] tx_cnt_q, tx_cnt_d;
   logic [2:0] rx_cnt_q, rx_cnt_d;
   logic txe_q, txe_d;
   logic tx_end_flag_q, tx_end_flag_d;
   logic rxf_q, rxf_d;
   logic ovr_q, ovr_d;
   logic tx_busy_q, tx_busy_d;
   logic txd_q, txd_d;
   logic pin_q, pin_d;
   logic sck_q, sck_d;
   logic ir_seen_q, ir_seen_d;
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic txi_q, txi_d;
   logic tei_q, tei_d;
   logic rxi_q, rxi_d;
   logic eri_q, eri_d;
   logic sck_s1, sck_s2, sck_s3;
   logic rxd_s1, rxd_s2;
   logic [4:0] addr_w;
   logic req_w, wr_w, rd_w;
   logic int_clk_w, ext_clk_w, err_w;
   logic tx_ok_w, load_w, rx_only_w, run_w;
   logic gen_tick_w, fall_ev_w, rise_ev_w;
   logic rx_on_w, rx_bit_w, rx_done_w;
   logic [7:0] rx_byte_w;

   // ---------------------------------------------------------------
   // Pin synchronisers.
   // ---------------------------------------------------------------
   // Each pin passes two flops; the third clock flop only feeds edges.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_s1 <= 1'b1;
         sck_s2 <= 1'b1;
         sck_s3 <= 1'b1;
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
      end else begin
         sck_s1 <= serial_clock_pin_a_i;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         rxd_s1 <= receive_pin_a_i;
         rxd_s2 <= rxd_s1;
      end
   end

   // ---------------------------------------------------------------
   // Decode of bus, clock source and serial events.
   // ---------------------------------------------------------------
   // The write takes effect on the edge that samples ack high.
   assign addr_w = {adr_i, 2'b00};
   assign req_w = cyc_i & stb_i;
   assign wr_w = req_w & ack_q & we_i & sel_i[0];
   assign rd_w = req_w & ack_q & ~we_i;
   // Only the two clocked synchronous codes run the shifters.
   assign int_clk_w = ctrl_q.sync_mode & ~ctrl_q.clock_source_sel1
      & ~ctrl_q.clock_source_sel0;
   assign ext_clk_w = ctrl_q.sync_mode & ctrl_q.clock_source_sel1
      & ~ctrl_q.clock_source_sel0;
   // Framing and parity cannot arise in this mode, so overrun alone.
   assign err_w = ovr_q;
   assign tx_ok_w = ctrl_q.transmitter_enable & ~txe_q & ~err_w;
   assign load_w = ~tx_busy_q & tx_ok_w
      & (int_clk_w | ext_clk_w);
   // Receive-only with the internal clock keeps the clock running.
   assign rx_only_w = int_clk_w & ctrl_q.receiver_enable
      & ~ctrl_q.transmitter_enable & ~err_w;
   assign run_w = tx_busy_q | rx_only_w;
   // A low clock always finishes its pulse, so it stops high.
   assign gen_tick_w = int_clk_w & (div_q == baud_q)
      & (run_w | ~sck_q);
   assign fall_ev_w = int_clk_w ? (gen_tick_w & sck_q)
      : (ext_clk_w & sck_s3 & ~sck_s2);
   assign rise_ev_w = int_clk_w ? (gen_tick_w & ~sck_q)
      : (ext_clk_w & ~sck_s3 & sck_s2);
   assign rx_on_w = ctrl_q.receiver_enable & ~err_w
      & (int_clk_w | ext_clk_w);
   // Any high level seen in the bit, however short, reads as zero.
   assign rx_bit_w = irc_q.infrared_enable ? ~(ir_seen_q | rxd_s2)
      : rxd_s2;
   assign rx_byte_w = {rx_bit_w, rx_sh_q[7:1]};
   assign rx_done_w = rx_on_w & rise_ev_w & (rx_cnt_q == LAST_BIT);

   // Pulse of 3/16 bit period, where one bit is two half periods.
   assign p3_w = (BAUD_W+3)'(3) * (BAUD_W+3)'({1'b0, baud_q} + 1'b1);
   assign pulse_w = (irc_q.pulse_width_select == PWS_DEFAULT)
      ? ((p3_w[BAUD_W+2:3] == '0) ? BAUD_W'(1) : p3_w[BAUD_W+2:3])
      : BAUD_W'(PULSE_MIN_CYC);

   // Status word as software reads it.
   always_comb begin
      stat_w = '0;
      stat_w.tx_empty_flag = txe_q;
      stat_w.rx_full_flag = rxf_q;
      stat_w.overrun_flag = ovr_q;
      stat_w.tx_end_flag = tx_end_flag_q;
   end

   // ---------------------------------------------------------------
   // Next-state logic.
   // ---------------------------------------------------------------
   // Bus effects come first so that hardware sets below win over them.
   always_comb begin
      ctrl_d = ctrl_q;
      irc_d = irc_q;
      baud_d = baud_q;
      div_d = div_q;
      ir_cnt_d = ir_cnt_q;
      tx_buf_d = tx_buf_q;
      rx_buf_d = rx_buf_q;
      tx_sh_d = tx_sh_q;
      rx_sh_d = rx_sh_q;
      tx_cnt_d = tx_cnt_q;
      rx_cnt_d = rx_cnt_q;
      txe_d = txe_q;
      tx_end_flag_d = tx_end_flag_q;
      rxf_d = rxf_q;
      ovr_d = ovr_q;
      tx_busy_d = tx_busy_q;
      txd_d = txd_q;
      sck_d = sck_q;
      ir_seen_d = ir_seen_q;
      ack_d = req_w & ~ack_q;
      dat_d = '0;

      // Read data is ready in the cycle that ack is high.
      if (req_w & ~ack_q & ~we_i) begin
         case (addr_w)
            OFF_CTRL: dat_d = {24'h000000, ctrl_q};
            OFF_STAT: dat_d = {24'h000000, stat_w};
            OFF_TXB: dat_d = {24'h000000, tx_buf_q};
            OFF_RXB: dat_d = {24'h000000, rx_buf_q};
            OFF_IRC: dat_d = {24'h000000, irc_q};
            OFF_BAUD: dat_d = 32'(baud_q);
            default: dat_d = '0;
         endcase
      end

      // Writes; the receive-full, overrun and transmit-end status bits are cleared by writing one.
      if (wr_w) begin
         case (addr_w)
            OFF_CTRL: ctrl_d = ctrl_s'(dat_i[7:0]);
            OFF_STAT: begin
               if (dat_i[6]) rxf_d = 1'b0;
               if (dat_i[5]) ovr_d = 1'b0;
               if (dat_i[2]) tx_end_flag_d = 1'b0;
            end
            OFF_TXB: begin
               tx_buf_d = dat_i[7:0];
               txe_d = 1'b0;
            end
            OFF_IRC: irc_d = irc_s'({dat_i[7:4], 4'h0});
            OFF_BAUD: baud_d = dat_i[BAUD_W-1:0];
            default: ;
         endcase
      end

      // Reading the receive buffer frees it.
      if (rd_w && addr_w == OFF_RXB) begin
         rxf_d = 1'b0;
      end

      // Transmit shifter.
      if (load_w) begin
         tx_sh_d = tx_buf_q;
         txe_d = 1'b1;
         tx_end_flag_d = 1'b0;
         tx_busy_d = 1'b1;
         tx_cnt_d = 3'h0;
      end else if (tx_busy_q && fall_ev_w) begin
         txd_d = tx_sh_q[0];
         tx_sh_d = {1'b0, tx_sh_q[7:1]};
         if (irc_q.infrared_enable && !tx_sh_q[0]) begin
            ir_cnt_d = pulse_w;
         end
      end else if (tx_busy_q && rise_ev_w) begin
         tx_cnt_d = tx_cnt_q + 3'h1;
         if (tx_cnt_q == LAST_BIT) begin
            if (tx_ok_w) begin
               tx_sh_d = tx_buf_q;
               txe_d = 1'b1;
            end else begin
               tx_busy_d = 1'b0;
               tx_end_flag_d = 1'b1;
            end
         end
      end

      // Infrared pulse timer counts system clocks down to zero.
      if (ir_cnt_q != '0 && !(tx_busy_q && fall_ev_w)) begin
         ir_cnt_d = ir_cnt_q - 1'b1;
      end

      // Turning the transmitter off resets it and empties the buffer.
      if (!ctrl_q.transmitter_enable) begin
         txe_d = 1'b1;
         tx_busy_d = 1'b0;
         tx_cnt_d = 3'h0;
      end

      // Receive shifter and pulse catcher.
      ir_seen_d = irc_q.infrared_enable & (ir_seen_q | rxd_s2);
      if (rise_ev_w) begin
         ir_seen_d = 1'b0;
      end
      if (!rx_on_w) begin
         rx_cnt_d = 3'h0;
      end else if (rise_ev_w) begin
         rx_sh_d = rx_byte_w;
         rx_cnt_d = rx_cnt_q + 3'h1;
         if (rx_done_w && rxf_q) begin
            ovr_d = 1'b1;
         end else if (rx_done_w) begin
            rx_buf_d = rx_byte_w;
            rxf_d = 1'b1;
         end
      end

      // Baud generator: each terminal count is one clock half period.
      if (int_clk_w && (run_w || !sck_q)) begin
         if (div_q == baud_q) begin
            div_d = '0;
            sck_d = ~sck_q;
         end else begin
            div_d = div_q + 1'b1;
         end
      end else begin
         div_d = '0;
         sck_d = 1'b1;
      end
   end

   // Output pin level and interrupt requests, kept in flops.
   always_comb begin
      pin_d = irc_q.infrared_enable ? (ir_cnt_d != '0) : txd_d;
      txi_d = txe_q & ctrl_q.tx_irq_enable;
      tei_d = tx_end_flag_q & ctrl_q.tx_end_irq_enable;
      rxi_d = rxf_q & ctrl_q.rx_irq_enable;
      eri_d = err_w & ctrl_q.rx_irq_enable;
   end

   // ---------------------------------------------------------------
   // Registers.
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= ctrl_s'(CTRL_RST);
         irc_q <= irc_s'(IRC_RST);
         baud_q <= BAUD_W'(BAUD_RST);
         div_q <= '0;
         ir_cnt_q <= '0;
         tx_buf_q <= 8'h00;
         rx_buf_q <= 8'h00;
         tx_sh_q <= 8'h00;
         rx_sh_q <= 8'h00;
         tx_cnt_q <= 3'h0;
         rx_cnt_q <= 3'h0;
         txe_q <= 1'b1;
         tx_end_flag_q <= 1'b1;
         rxf_q <= 1'b0;
         ovr_q <= 1'b0;
         tx_busy_q <= 1'b0;
         txd_q <= 1'b1;
         pin_q <= 1'b1;
         sck_q <= 1'b1;
         ir_seen_q <= 1'b0;
         ack_q <= 1'b0;
         dat_q <= '0;
         txi_q <= 1'b0;
         tei_q <= 1'b0;
         rxi_q <= 1'b0;
         eri_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         irc_q <= irc_d;
         baud_q <= baud_d;
         div_q <= div_d;
         ir_cnt_q <= ir_cnt_d;
         tx_buf_q <= tx_buf_d;
         rx_buf_q <= rx_buf_d;
         tx_sh_q <= tx_sh_d;
         rx_sh_q <= rx_sh_d;
         tx_cnt_q <= tx_cnt_d;
         rx_cnt_q <= rx_cnt_d;
         txe_q <= txe_d;
         tx_end_flag_q <= tx_end_flag_d;
         rxf_q <= rxf_d;
         ovr_q <= ovr_d;
         tx_busy_q <= tx_busy_d;
         txd_q <= txd_d;
         pin_q <= pin_d;
         sck_q <= sck_d;
         ir_seen_q <= ir_seen_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
         txi_q <= txi_d;
         tei_q <= tei_d;
         rxi_q <= rxi_d;
         eri_q <= eri_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs.
   // ---------------------------------------------------------------
   assign ack_o = ack_q;
   assign dat_o = dat_q;
   assign serial_clock_pin_a_o = sck_q;
   assign serial_clock_pin_a_oe_o = int_clk_w;
   assign transmit_pin_a_o = pin_q;
   assign tx_empty_request_o = txi_q;
   assign tx_end_request_o = tei_q;
   assign rx_full_request_o = rxi_q;
   assign rx_error_request_o = eri_q;

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   tx_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      load_w |=> txe_q && tx_busy_q && tx_sh_q == $past(tx_buf_q))
      else $error("transmit load did not take the buffer");

   tx_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(txd_q) |-> $past(fall_ev_w) && $past(tx_busy_q))
      else $error("transmit line moved off a falling edge");

   rx_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(rx_sh_q) |-> $past(rise_ev_w))
      else $error("receive shifter moved off a rising edge");

   sck_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(sck_q) |-> $past(run_w))
      else $error("serial clock fell while idle");

   tx_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_busy_q && rise_ev_w && tx_cnt_q == LAST_BIT && !tx_ok_w
      && ctrl_q.transmitter_enable)
      |=> tx_end_flag_q && !tx_busy_q && $stable(txd_q) ##1 tei_q
      == $past(ctrl_q.tx_end_irq_enable))
      else $error("transmit end not flagged");

   err_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ovr_q |-> !load_w && !rx_on_w)
      else $error("transfer started with an error flag set");

   rx_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_done_w && !rxf_q) |=> rxf_q && rx_buf_q == $past(rx_byte_w))
      else $error("received byte not stored");

   overrun_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_done_w && rxf_q) |=> ovr_q && rxf_q && $stable(rx_buf_q))
      else $error("overrun not handled");

   ir_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (irc_q.infrared_enable && tx_busy_q && fall_ev_w && !tx_sh_q[0])
      |=> ir_cnt_q == $past(pulse_w) && transmit_pin_a_o)
      else $error("zero bit gave no infrared pulse");

   err_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ovr_q && ctrl_q.rx_irq_enable) [*2] |-> rx_error_request_o)
      else $error("error request missing");

   reset_flag_a: assert property (@(posedge clk_i)
      $past(rst_i) && !rst_i |-> txe_q && tx_end_flag_q)
      else $error("empty flag not set after reset");

endmodule

// File: sim/serial_peer.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Synchronous serial peer that supplies the serial clock.
// ---------------------------------------------------------------
// The clock stands high between frames. The data line has no pull,
// so after a frame it shows the inverse of its last bit.
module serial_peer (
   output logic sck_o,
   output logic rxd_o,
   input wire logic txd_i
);
   initial begin
      sck_o = 1'b1;
      rxd_o = 1'b1;
   end

   // One character of eight pulses, sent LSB first, read on the rise.
   task automatic frame(input logic [7:0] send, output logic [7:0] got);
      for (int i = 0; i < 8; i++) begin
         #200 sck_o = 1'b0;
         rxd_o = send[i];
         #200 sck_o = 1'b1;
         got[i] = txd_i;
      end
      #200 rxd_o = ~send[7];
   endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import serial_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
   logic we_i = 1'b0, ack_o, sck_out, sck_oe, txd, peer_sck, rxd;
   logic [2:0] adr_i = 3'h0;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic tx_req, end_req, full_req, err_req, ir_on = 1'b0;
   logic sck_prev = 1'b1, txd_prev = 1'b1;
   logic [15:0] cap_q = 16'h0;
   logic [7:0] got;
   int errors = 0, compares = 0, n_rise = 0, bad_edge = 0;
   int pulses = 0, run = 0, last_w = 0, base, base_p;
   wire sck_wire = sck_oe ? sck_out : peer_sck;

   always #25 clk_i = ~clk_i;

   sync_serial_ir i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
      .serial_clock_pin_a_i(sck_wire), .serial_clock_pin_a_o(sck_out),
      .serial_clock_pin_a_oe_o(sck_oe), .receive_pin_a_i(rxd),
      .transmit_pin_a_o(txd), .tx_empty_request_o(tx_req),
      .tx_end_request_o(end_req), .rx_full_request_o(full_req),
      .rx_error_request_o(err_req));

   serial_peer i_peer (.sck_o(peer_sck), .rxd_o(rxd), .txd_i(txd));

   // ---------------------------------------------------------------
   // Line monitor.
   // ---------------------------------------------------------------
   // Captures data on internal clock rises, flags data changes while
   // the clock stays high, and measures infrared pulse widths.
   always @(posedge clk_i) begin
      if (sck_oe === 1'b1 && sck_prev === 1'b0 && sck_out === 1'b1) begin
         cap_q = {txd, cap_q[15:1]};
         n_rise++;
      end
      if (sck_oe && sck_prev && sck_out && txd !== txd_prev && !ir_on)
         bad_edge++;
      if (txd === 1'b1) begin
         run++;
      end else if (run > 0) begin
         last_w = run;
         pulses++;
         run = 0;
      end
      sck_prev = sck_out;
      txd_prev = txd;
   end

   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Classic single cycle; the request holds until ack is sampled.
   task automatic bus(input logic w, input logic [4:0] off,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= off[4:2];
      dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] off, input logic [7:0] v);
      bus(1'b1, off, {24'h0, v});
   endtask

   task automatic rd_chk(input logic [4:0] off, input logic [7:0] e);
      bus(1'b0, off, 32'h0);
      chk(rd, {24'h0, e});
   endtask

   task automatic wait_rise(input int target);
      int n;
      n = 0;
      while (n_rise < target && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 3000) errors++;
      repeat (40) @(posedge clk_i);
   endtask

   task automatic peer_frame(input logic [7:0] v);
      @(posedge clk_i);
      #7;
      i_peer.frame(v, got);
      repeat (10) @(posedge clk_i);
   endtask

   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   // Reset values, an unmapped word, and the idle-high serial clock.
   task automatic test_reset;
      rd_chk(OFF_CTRL, CTRL_RST);
      rd_chk(OFF_STAT, 8'h84);
      rd_chk(5'h18, 8'h00);
      chk({31'h0, sck_out}, 32'h1);
   endtask

   // Two bytes back to back on the internal clock, then a clean stop.
   task automatic test_tx_internal;
      wr(OFF_BAUD, 8'h03);
      wr(OFF_CTRL, 8'h96);
      repeat (2) @(posedge clk_i);
      chk({30'h0, tx_req, end_req}, 32'h3);
      chk({31'h0, sck_oe}, 32'h1);
      wr(OFF_TXB, 8'hA5);
      wr(OFF_TXB, 8'h3C);
      wait_rise(16);
      chk({16'h0, cap_q}, 32'h3CA5);
      chk(n_rise, 16);
      rd_chk(OFF_STAT, 8'h84);
      chk({29'h0, sck_out, txd, end_req}, 32'h5);
      chk(bad_edge, 0);
   endtask

   // External clock: receive, overrun, blocked transmit, duplex.
   task automatic test_external;
      wr(OFF_CTRL, 8'h80);
      wr(OFF_STAT, 8'h04);
      wr(OFF_CTRL, 8'hCB);
      // The new mode lands at the ack edge, so let one edge pass first.
      @(posedge clk_i);
      chk({31'h0, sck_oe}, 32'h0);
      peer_frame(8'h5A);
      chk({31'h0, full_req}, 32'h1);
      rd_chk(OFF_STAT, 8'hC0);
      rd_chk(OFF_RXB, 8'h5A);
      peer_frame(8'h33);
      peer_frame(8'hCC);
      rd_chk(OFF_STAT, 8'hE0);
      chk({31'h0, err_req}, 32'h1);
      wr(OFF_CTRL, 8'hCB);
      wr(OFF_TXB, 8'h96);
      peer_frame(8'h11);
      rd_chk(OFF_STAT, 8'h60);
      rd_chk(OFF_RXB, 8'h33);
      wr(OFF_STAT, 8'h20);
      repeat (4) @(posedge clk_i);
      rd_chk(OFF_STAT, 8'h80);
      peer_frame(8'h77);
      chk({24'h0, got}, 32'h96);
      rd_chk(OFF_RXB, 8'h77);
      // Transmit-only to duplex: receiver off, receive flags clear, both on.
      wr(OFF_CTRL, 8'hCA);
      rd_chk(OFF_STAT, 8'h84);
      wr(OFF_CTRL, 8'hCB);
   endtask

   // Infrared pulses at the default width and at the fixed PULSE_MIN_CYC width.
   task automatic test_infrared;
      wr(OFF_CTRL, 8'h80);
      ir_on = 1'b1;
      wr(OFF_BAUD, 8'h0F);
      wr(OFF_IRC, 8'h80);
      wr(OFF_CTRL, 8'h82);
      base = n_rise;
      base_p = pulses;
      wr(OFF_TXB, 8'h0F);
      wait_rise(base + 8);
      chk(pulses - base_p, 4);
      chk(last_w, 6);
      wr(OFF_IRC, 8'hA0);
      // The idle receive line stands high, so every bit decodes as zero.
      wr(OFF_CTRL, 8'h83);
      base = n_rise;
      base_p = pulses;
      wr(OFF_TXB, 8'hFE);
      wait_rise(base + 8);
      chk(pulses - base_p, 1);
      chk(last_w, PULSE_MIN_CYC);
      rd_chk(OFF_RXB, 8'h00);
   endtask

   task automatic complete_run;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog.
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      test_reset();
      test_tx_internal();
      test_external();
      test_infrared();
      complete_run();
   end

   // The whole run needs well under a tenth of this span.
   initial begin
      #(40000 * 50);
      errors++;
      complete_run();
   end
endmodule
